/* File: core/ea_pkg.sv */
package ea_pkg;

    // Mode field codes
    localparam logic [2:0] MODE_DREG    = 3'h0;
    localparam logic [2:0] MODE_AREG    = 3'h1;
    localparam logic [2:0] MODE_IND     = 3'h2;
    localparam logic [2:0] MODE_POSTINC = 3'h3;
    localparam logic [2:0] MODE_PREDEC  = 3'h4;
    localparam logic [2:0] MODE_DISP16  = 3'h5;
    localparam logic [2:0] MODE_INDEX8  = 3'h6;
    localparam logic [2:0] MODE_EXT     = 3'h7;

    // Register field codes under the extended mode
    localparam logic [2:0] REG_ABS_W     = 3'h0;
    localparam logic [2:0] REG_ABS_L     = 3'h1;
    localparam logic [2:0] REG_PC_DISP16 = 3'h2;
    localparam logic [2:0] REG_PC_INDEX8 = 3'h3;
    localparam logic [2:0] REG_IMM       = 3'h4;

    // Index extension word layout
    localparam int IDX_AREG_BIT  = 15;
    localparam int IDX_REG_MSB   = 14;
    localparam int IDX_REG_LSB   = 12;
    localparam int IDX_LONG_BIT  = 11;
    localparam int IDX_SCALE_MSB = 10;
    localparam int IDX_SCALE_LSB = 9;
    localparam int MUL_LONG_BIT  = 10;

    // Address offsets
    localparam logic [31:0] PC_EXT_OFFSET   = 32'h0000_0002;
    localparam logic [31:0] LOW_WORD_OFFSET = 32'h0000_0002;
    localparam logic [31:0] LOW_BYTE_OFFSET = 32'h0000_0001;

    // Trap instruction and the multiply-accumulate line
    localparam logic [11:0] TRAP_PATTERN = 12'h4E4;
    localparam int          TRAP_VEC_W   = 4;
    localparam logic [3:0]  MAC_LINE     = 4'hA;

    // Removed operations: mask and pattern per entry
    localparam int REMOVED_N = 8;
    localparam int ROT_REG_ENTRY = 4;
    localparam int MUL64_ENTRY = 7;
    localparam logic [REMOVED_N-1:0][15:0] REMOVED_MASK = {
        16'hFFC0, 16'hF0F8, 16'hFEC0, 16'hF018,
        16'hF8C0, 16'hFFC0, 16'hF1F0, 16'hF1F0};
    localparam logic [REMOVED_N-1:0][15:0] REMOVED_VALUE = {
        16'h4C00, 16'h50C8, 16'hE6C0, 16'hE018,
        16'hE8C0, 16'h4800, 16'h8100, 16'hC100};

    typedef enum logic [3:0] {
        EA_DREG, EA_AREG, EA_IND, EA_POSTINC, EA_PREDEC, EA_DISP16,
        EA_INDEX8, EA_ABS_W, EA_ABS_L, EA_PC_DISP16, EA_PC_INDEX8,
        EA_IMM, EA_INVALID
    } ea_mode_t;

    typedef enum logic [1:0] {
        SIZE_BYTE, SIZE_WORD, SIZE_LONG, SIZE_RSVD
    } op_size_t;

    typedef struct packed {
        logic data;
        logic memory;
        logic control;
        logic alterable;
        logic alt_memory;
        logic data_alt;
    } ea_cat_t;

    typedef struct packed {
        logic        valid;
        logic [15:0] op_word;
        logic [2:0]  mode;
        logic [2:0]  regf;
        op_size_t    size;
        logic [15:0] ext0;
        logic [15:0] ext1;
        logic [31:0] base_value;
        logic [31:0] pc_value;
        logic [31:0] index_value;
    } ea_req_t;

    typedef struct packed {
        logic        valid;
        ea_mode_t    mode;
        logic [2:0]  reg_num;
        ea_cat_t     cat;
        logic [1:0]  ext_words;
        logic [31:0] address;
        logic [31:0] immediate;
        logic        an_update;
        logic [31:0] an_next;
        logic        idx_is_areg;
        logic [2:0]  idx_num;
        logic        bad_scale;
    } ea_result_t;

    typedef struct packed {
        logic [31:0] first_addr;
        logic [15:0] first_part;
        logic [31:0] second_addr;
        logic [15:0] second_part;
        logic        two_parts;
    } mem_layout_t;

endpackage : ea_pkg

/* File: core/mem_order.sv */
module mem_order (
    // Operand to place
    input  wire logic [31:0]      addr,
    input  ea_pkg::op_size_t      size,
    input  wire logic [31:0]      data,
    // Placement, most significant part first
    output ea_pkg::mem_layout_t   layout
);

    wire is_long = size == ea_pkg::SIZE_LONG;
    wire is_word = size == ea_pkg::SIZE_WORD;

    // Lower addresses take higher-order parts
    assign layout.first_addr  = addr;
    assign layout.second_addr = is_long ? addr + ea_pkg::LOW_WORD_OFFSET
                                        : addr + ea_pkg::LOW_BYTE_OFFSET;
    assign layout.first_part  = is_long ? data[31:16]
                              : is_word ? {8'h00, data[15:8]}
                              : {8'h00, data[7:0]};
    assign layout.second_part = is_long ? data[15:0]
                              : {8'h00, data[7:0]};
    // A byte fits in one access, the second part is unused
    assign layout.two_parts   = is_long | is_word;

endmodule : mem_order

/* File: core/ea_mode_decoder.sv */
module ea_mode_decoder (
    // Clock, reset, enable
    input  wire logic                 clk,
    input  wire logic                 rst,
    input  wire logic                 ce,
    // Operand specifier with register values
    input  ea_pkg::ea_req_t           req,
    input  wire logic [31:0]          store_data,
    // Register source and destination merge
    input  wire logic [31:0]          src_value,
    input  wire logic                 src_is_areg,
    input  wire logic [31:0]          dest_old,
    input  wire logic [31:0]          alu_result,
    input  wire logic                 dest_is_areg,
    input  ea_pkg::op_size_t          reg_size,
    // Status word and flag writes
    input  wire logic [15:0]          status_word,
    input  wire logic                 flags_we,
    input  wire logic [7:0]           flags_wdata,
    // Decode results
    output ea_pkg::ea_result_t        result,
    output ea_pkg::mem_layout_t       layout,
    output logic [31:0]               src_operand,
    output logic [31:0]               dest_merged,
    output logic [7:0]                condition_flags,
    output logic [15:0]               next_status_word,
    output logic                      trap_valid,
    output logic [3:0]                trap_vector,
    output logic                      mac_op,
    output logic                      removed_op
);

    // Mode from the two fields
    function automatic ea_pkg::ea_mode_t decode_mode(
        input logic [2:0] m,
        input logic [2:0] r
    );
        ea_pkg::ea_mode_t md;
        md = ea_pkg::EA_INVALID;
        case (m)
            ea_pkg::MODE_DREG:    md = ea_pkg::EA_DREG;
            ea_pkg::MODE_AREG:    md = ea_pkg::EA_AREG;
            ea_pkg::MODE_IND:     md = ea_pkg::EA_IND;
            ea_pkg::MODE_POSTINC: md = ea_pkg::EA_POSTINC;
            ea_pkg::MODE_PREDEC:  md = ea_pkg::EA_PREDEC;
            ea_pkg::MODE_DISP16:  md = ea_pkg::EA_DISP16;
            ea_pkg::MODE_INDEX8:  md = ea_pkg::EA_INDEX8;
            ea_pkg::MODE_EXT: begin
                case (r)
                    ea_pkg::REG_ABS_W:     md = ea_pkg::EA_ABS_W;
                    ea_pkg::REG_ABS_L:     md = ea_pkg::EA_ABS_L;
                    ea_pkg::REG_PC_DISP16: md = ea_pkg::EA_PC_DISP16;
                    ea_pkg::REG_PC_INDEX8: md = ea_pkg::EA_PC_INDEX8;
                    ea_pkg::REG_IMM:       md = ea_pkg::EA_IMM;
                    default:               md = ea_pkg::EA_INVALID;
                endcase
            end
            default: md = ea_pkg::EA_INVALID;
        endcase
        return md;
    endfunction : decode_mode

    // Base categories as {data, memory, control, alterable}
    function automatic logic [3:0] base_cat(input ea_pkg::ea_mode_t md);
        logic [3:0] c;
        c = 4'h0;
        case (md)
            ea_pkg::EA_DREG:      c = 4'h9;
            ea_pkg::EA_AREG:      c = 4'h1;
            ea_pkg::EA_IND:       c = 4'hF;
            ea_pkg::EA_POSTINC:   c = 4'hD;
            ea_pkg::EA_PREDEC:    c = 4'hD;
            ea_pkg::EA_DISP16:    c = 4'hF;
            ea_pkg::EA_INDEX8:    c = 4'hF;
            ea_pkg::EA_ABS_W:     c = 4'hE;
            ea_pkg::EA_ABS_L:     c = 4'hE;
            ea_pkg::EA_PC_DISP16: c = 4'hE;
            ea_pkg::EA_PC_INDEX8: c = 4'hE;
            ea_pkg::EA_IMM:       c = 4'hC;
            default:              c = 4'h0;
        endcase
        return c;
    endfunction : base_cat

    // Operand size in bytes; reserved code treated as longword
    function automatic logic [31:0] size_bytes(input ea_pkg::op_size_t s);
        logic [31:0] n;
        n = 32'h0000_0004;
        case (s)
            ea_pkg::SIZE_BYTE: n = 32'h0000_0001;
            ea_pkg::SIZE_WORD: n = 32'h0000_0002;
            ea_pkg::SIZE_LONG: n = 32'h0000_0004;
            default:           n = 32'h0000_0004;
        endcase
        return n;
    endfunction : size_bytes

    // Decoded mode and categories
    ea_pkg::ea_mode_t next_mode;
    ea_pkg::ea_cat_t  next_cat;
    logic [3:0]       cat4;

    assign next_mode = decode_mode(req.mode, req.regf);
    assign cat4      = base_cat(next_mode);
    assign next_cat.data       = cat4[3];
    assign next_cat.memory     = cat4[2];
    assign next_cat.control    = cat4[1];
    assign next_cat.alterable  = cat4[0];
    assign next_cat.alt_memory = cat4[0] & cat4[2];
    assign next_cat.data_alt   = cat4[0] & cat4[3];

    // Mode groups used below
    wire is_imm    = next_mode == ea_pkg::EA_IMM;
    wire is_abs_l  = next_mode == ea_pkg::EA_ABS_L;
    wire is_pc     = next_mode == ea_pkg::EA_PC_DISP16
                   | next_mode == ea_pkg::EA_PC_INDEX8;
    wire is_index  = next_mode == ea_pkg::EA_INDEX8
                   | next_mode == ea_pkg::EA_PC_INDEX8;
    wire is_disp16 = next_mode == ea_pkg::EA_DISP16
                   | next_mode == ea_pkg::EA_PC_DISP16;
    wire is_abs_w  = next_mode == ea_pkg::EA_ABS_W;
    wire is_postinc = next_mode == ea_pkg::EA_POSTINC;
    wire is_predec  = next_mode == ea_pkg::EA_PREDEC;
    wire is_long   = req.size == ea_pkg::SIZE_LONG;

    // Extension words that follow the operation word
    wire [1:0] next_ext_words =
        (is_abs_l | (is_imm & is_long)) ? 2'h2
        : (is_imm | is_disp16 | is_index | is_abs_w) ? 2'h1
        : 2'h0;

    // Displacements widened before any addition
    wire [31:0] disp16 = {{16{req.ext0[15]}}, req.ext0};
    wire [31:0] disp8  = {{24{req.ext0[7]}}, req.ext0[7:0]};

    // Index register: either file, word form sign-extended
    wire        idx_is_areg = req.ext0[ea_pkg::IDX_AREG_BIT];
    wire [2:0]  idx_num =
        req.ext0[ea_pkg::IDX_REG_MSB:ea_pkg::IDX_REG_LSB];
    wire [31:0] idx_raw = req.ext0[ea_pkg::IDX_LONG_BIT]
                        ? req.index_value
                        : {{16{req.index_value[15]}}, req.index_value[15:0]};
    wire [1:0]  scale_code =
        req.ext0[ea_pkg::IDX_SCALE_MSB:ea_pkg::IDX_SCALE_LSB];
    // Scale code 11 has no factor; flagged and treated as x1
    wire        bad_scale = is_index & (&scale_code);
    wire [31:0] idx_scaled =
        scale_code == 2'h1 ? {idx_raw[30:0], 1'b0}
        : scale_code == 2'h2 ? {idx_raw[29:0], 2'h0}
        : idx_raw;

    // Base: address register, or PC at the first extension word
    wire [31:0] pc_base = req.pc_value + ea_pkg::PC_EXT_OFFSET;
    wire [31:0] base    = is_pc ? pc_base : req.base_value;
    wire [31:0] step    = size_bytes(req.size);

    // Effective address per mode
    wire [31:0] next_address =
        is_predec ? req.base_value - step
        : is_disp16 ? base + disp16
        : is_index ? base + disp8 + idx_scaled
        : is_abs_w ? disp16
        : is_abs_l ? {req.ext0, req.ext1}
        : req.base_value;

    // Address register write-back for auto-update modes
    wire        next_an_update = is_postinc | is_predec;
    wire [31:0] next_an_next = is_postinc ? req.base_value + step
                                          : req.base_value - step;

    // Immediate from the words after the operation word
    wire [31:0] next_imm =
        req.size == ea_pkg::SIZE_BYTE ? {24'h00_0000, req.ext0[7:0]}
        : req.size == ea_pkg::SIZE_WORD ? {16'h0000, req.ext0}
        : {req.ext0, req.ext1};

    // Register source: address register word is sign-extended
    wire [31:0] next_src =
        reg_size == ea_pkg::SIZE_BYTE ? {24'h00_0000, src_value[7:0]}
        : reg_size == ea_pkg::SIZE_WORD
        ? (src_is_areg ? {{16{src_value[15]}}, src_value[15:0]}
                       : {16'h0000, src_value[15:0]})
        : src_value;

    // Destination: address register takes all bits, data keeps upper
    wire [31:0] next_dest =
        dest_is_areg
          ? (reg_size == ea_pkg::SIZE_WORD
             ? {{16{alu_result[15]}}, alu_result[15:0]}
             : alu_result)
        : reg_size == ea_pkg::SIZE_BYTE
          ? {dest_old[31:8], alu_result[7:0]}
        : reg_size == ea_pkg::SIZE_WORD
          ? {dest_old[31:16], alu_result[15:0]}
        : alu_result;

    // Flags live in the status word's low byte only
    wire [7:0]  next_flags = status_word[7:0];
    wire [15:0] next_sw = flags_we ? {status_word[15:8], flags_wdata}
                                   : status_word;

    // Trap vector field
    wire                  next_trap = req.valid
        & req.op_word[15:4] == ea_pkg::TRAP_PATTERN;
    localparam int TRAP_W = ea_pkg::TRAP_VEC_W;
    wire [TRAP_W-1:0]     next_vec = req.op_word[TRAP_W-1:0];

    // Multiply-accumulate line
    wire next_mac = req.valid
        & req.op_word[15:12] == ea_pkg::MAC_LINE;

    // Removed operation patterns, one matcher per entry
    logic [ea_pkg::REMOVED_N-1:0] removed_hit;
    logic [ea_pkg::REMOVED_N-1:0] removed_qual;
    genvar gi;
    generate
        for (gi = 0; gi < ea_pkg::REMOVED_N; gi++) begin : g_removed
            assign removed_hit[gi] =
                (req.op_word & ea_pkg::REMOVED_MASK[gi])
                == ea_pkg::REMOVED_VALUE[gi];
            // Extra qualifiers keep legal neighbours from matching
            if (gi == ea_pkg::ROT_REG_ENTRY) begin : g_rot
                assign removed_qual[gi] = ~&req.op_word[7:6];
            end else if (gi == ea_pkg::MUL64_ENTRY) begin : g_mul
                assign removed_qual[gi] = req.ext0[ea_pkg::MUL_LONG_BIT];
            end else begin : g_plain
                assign removed_qual[gi] = 1'b1;
            end
        end
    endgenerate
    wire next_removed = req.valid
        & |(removed_hit & removed_qual);

    // Memory placement of the store operand
    ea_pkg::mem_layout_t next_layout;
    mem_order u_mem_order (
        .addr   (next_address),
        .size   (req.size),
        .data   (store_data),
        .layout (next_layout)
    );

    // Assembled decode result
    ea_pkg::ea_result_t next_result;
    assign next_result.valid       = req.valid;
    assign next_result.mode        = next_mode;
    assign next_result.reg_num     = req.regf;
    assign next_result.cat         = next_cat;
    assign next_result.ext_words   = next_ext_words;
    assign next_result.address     = next_address;
    assign next_result.immediate   = next_imm;
    assign next_result.an_update   = req.valid & next_an_update;
    assign next_result.an_next     = next_an_next;
    assign next_result.idx_is_areg = idx_is_areg;
    assign next_result.idx_num     = idx_num;
    assign next_result.bad_scale   = bad_scale;

    // Decode results; held while enable is low
    always_ff @(posedge clk) begin
        if (rst) begin
            result <= '0;
            layout <= '0;
        end else if (ce) begin
            result <= next_result;
            layout <= next_layout;
        end
    end

    // Register merge outputs
    always_ff @(posedge clk) begin
        if (rst) begin
            src_operand <= 32'h0000_0000;
            dest_merged <= 32'h0000_0000;
        end else if (ce) begin
            src_operand <= next_src;
            dest_merged <= next_dest;
        end
    end

    // Status word view
    always_ff @(posedge clk) begin
        if (rst) begin
            condition_flags  <= 8'h00;
            next_status_word <= 16'h0000;
        end else if (ce) begin
            condition_flags  <= next_flags;
            next_status_word <= next_sw;
        end
    end

    // Instruction class flags
    always_ff @(posedge clk) begin
        if (rst) begin
            trap_valid  <= 1'b0;
            trap_vector <= 4'h0;
            mac_op      <= 1'b0;
            removed_op  <= 1'b0;
        end else if (ce) begin
            trap_valid  <= next_trap;
            trap_vector <= next_vec;
            mac_op      <= next_mac;
            removed_op  <= next_removed;
        end
    end

endmodule : ea_mode_decoder

/* File: dv/ea_mode_decoder_monitor.sv */
module ea_mode_decoder_monitor (
    // Clock, reset and enable
    input  wire logic            clk,
    input  wire logic            rst,
    input  wire logic            ce,
    // Watched inputs
    input  ea_pkg::ea_req_t      req,
    input  wire logic [31:0]     store_data,
    input  wire logic [31:0]     src_value,
    input  wire logic            src_is_areg,
    input  ea_pkg::op_size_t     reg_size,
    input  wire logic [15:0]     status_word,
    input  wire logic            flags_we,
    input  wire logic [7:0]      flags_wdata,
    // Watched outputs
    input  ea_pkg::ea_result_t   result,
    input  ea_pkg::mem_layout_t  layout,
    input  wire logic [31:0]     src_operand,
    input  wire logic [7:0]      condition_flags,
    input  wire logic [15:0]     next_status_word,
    input  wire logic            trap_valid,
    input  wire logic [3:0]      trap_vector
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    // Causes sampled one enabled edge earlier; go keeps reset edges out
    wire go = ce & ~rst;
    wire [7:0] sw_lo = status_word[7:0];
    wire [15:0] sw_nx = flags_we ? {status_word[15:8], flags_wdata}
                                 : status_word;
    wire trap_hit = req.valid & (req.op_word[15:4] == ea_pkg::TRAP_PATTERN);
    wire [3:0] vec = req.op_word[3:0];
    wire is_long = req.size == ea_pkg::SIZE_LONG;
    wire is_word = req.size == ea_pkg::SIZE_WORD;
    wire [15:0] sd_hi = store_data[31:16];
    wire [7:0] sd_b1 = store_data[15:8];
    wire imm_l = req.valid & is_long & (req.mode == ea_pkg::MODE_EXT)
                 & (req.regf == ea_pkg::REG_IMM);
    wire [31:0] ext_pair = {req.ext0, req.ext1};
    wire src_aw = src_is_areg & (reg_size == ea_pkg::SIZE_WORD);
    wire [31:0] src_sext = {{16{src_value[15]}}, src_value[15:0]};
    wire pc_abs = result.valid & (result.mode >= ea_pkg::EA_ABS_W)
                  & (result.mode <= ea_pkg::EA_PC_INDEX8);
    wire auto_upd = result.valid & ((result.mode == ea_pkg::EA_POSTINC)
                    | (result.mode == ea_pkg::EA_PREDEC));

    property p_flags; $past(go) |-> condition_flags == $past(sw_lo)
        && next_status_word == $past(sw_nx); endproperty
    a_flags: assert property (p_flags)
        else $error("flag byte mismatch");
    property p_trap; $past(go) && $past(trap_hit) |-> trap_valid
        && trap_vector == $past(vec); endproperty
    a_trap: assert property (p_trap)
        else $error("trap vector mismatch");
    property p_long; $past(go) && $past(is_long) |-> layout.two_parts
        && layout.second_addr == layout.first_addr + 32'h2
        && layout.first_part == $past(sd_hi); endproperty
    a_long: assert property (p_long)
        else $error("longword order wrong");
    property p_word; $past(go) && $past(is_word) |-> layout.two_parts
        && layout.second_addr == layout.first_addr + 32'h1
        && layout.first_part[7:0] == $past(sd_b1); endproperty
    a_word: assert property (p_word)
        else $error("word order wrong");
    property p_combo; result.cat.alt_memory == (result.cat.alterable
        & result.cat.memory) && result.cat.data_alt
        == (result.cat.alterable & result.cat.data); endproperty
    a_combo: assert property (p_combo)
        else $error("combined category wrong");
    property p_fixed; pc_abs |-> result.cat[5:2] == 4'hE; endproperty
    a_fixed: assert property (p_fixed)
        else $error("fixed mode category wrong");
    property p_auto; auto_upd |-> result.cat[5:2] == 4'hD; endproperty
    a_auto: assert property (p_auto)
        else $error("auto update category wrong");
    property p_imm; $past(go) && $past(imm_l)
        |-> result.immediate == $past(ext_pair); endproperty
    a_imm: assert property (p_imm)
        else $error("immediate words wrong");
    property p_src; $past(go) && $past(src_aw)
        |-> src_operand == $past(src_sext); endproperty
    a_src: assert property (p_src)
        else $error("word source not extended");
endmodule : ea_mode_decoder_monitor

bind ea_mode_decoder ea_mode_decoder_monitor u_mon (.clk, .rst, .ce, .req,
    .store_data, .src_value, .src_is_areg, .reg_size, .status_word,
    .flags_we, .flags_wdata, .result, .layout, .src_operand,
    .condition_flags, .next_status_word, .trap_valid, .trap_vector);

/* File: dv/test_ea_mode_decoder.sv */
module test_ea_mode_decoder;
    timeunit 1ns;
    timeprecision 1ps;

    // One table row: specifier beside expected mode, category, value
    typedef struct packed {
        logic [2:0]  m;
        logic [2:0]  r;
        logic [1:0]  sz;
        logic [15:0] e0;
        logic [15:0] e1;
        logic [3:0]  em;
        logic [5:0]  cat;
        logic [1:0]  k;
        logic [31:0] ev;
    } row_t;

    logic clk, rst, ce, src_is_areg, dest_is_areg, flags_we;
    logic trap_valid, mac_op, removed_op;
    logic [31:0] store_data, src_value, dest_old, alu_result;
    logic [31:0] src_operand, dest_merged;
    logic [15:0] status_word, next_status_word;
    logic [7:0]  flags_wdata, condition_flags;
    logic [3:0]  trap_vector;
    ea_pkg::ea_req_t     req;
    ea_pkg::op_size_t    reg_size;
    ea_pkg::ea_result_t  result;
    ea_pkg::mem_layout_t layout;
    int err_count, checked, cycles;
    row_t rows [$];
    logic [15:0] ops [10];

    ea_mode_decoder dut (.clk, .rst, .ce, .req, .store_data, .src_value,
        .src_is_areg, .dest_old, .alu_result, .dest_is_areg, .reg_size,
        .status_word, .flags_we, .flags_wdata, .result, .layout,
        .src_operand, .dest_merged, .condition_flags, .next_status_word,
        .trap_valid, .trap_vector, .mac_op, .removed_op);

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Inputs change at the falling edge, outputs read at the next falling edge
    task automatic tick;
        @(posedge clk);
        @(negedge clk);
    endtask : tick

    task automatic end_of_test;
        if (err_count == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_of_test

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // Whole run is under a hundred cycles; this only catches a hang
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            err_count++;
            end_of_test;
        end
    end

    initial begin
        {rst, ce, src_is_areg, dest_is_areg, flags_we} = 5'h1C;
        {store_data, src_value, dest_old, alu_result} = '0;
        status_word = 16'h0000;
        flags_wdata = 8'h00;
        reg_size = ea_pkg::SIZE_BYTE;
        req = '0;
        req.valid = 1'b1;
        req.base_value = 32'h0000_0100;
        req.pc_value = 32'h0000_1000;
        req.index_value = 32'h0000_0008;
        rows = '{'{3'h0, 3'h3, 2'h2, 16'h0, 16'h0, 4'h0, 6'h25, 2'h0, 32'h0},
            '{3'h1, 3'h1, 2'h2, 16'h0, 16'h0, 4'h1, 6'h04, 2'h0, 32'h0},
            '{3'h2, 3'h2, 2'h2, 16'h0, 16'h0, 4'h2, 6'h3F, 2'h1, 32'h100},
            '{3'h3, 3'h5, 2'h2, 16'h0, 16'h0, 4'h3, 6'h37, 2'h1, 32'h100},
            '{3'h4, 3'h6, 2'h1, 16'h0, 16'h0, 4'h4, 6'h37, 2'h1, 32'hFE},
            '{3'h4, 3'h6, 2'h0, 16'h0, 16'h0, 4'h4, 6'h37, 2'h1, 32'hFF},
            '{3'h5, 3'h2, 2'h2, 16'hFFFE, 16'h0, 4'h5, 6'h3F, 2'h1, 32'hFE},
            '{3'h6, 3'h0, 2'h2, 16'hBCFC, 16'h0, 4'h6, 6'h3F, 2'h1, 32'h11C},
            '{3'h6, 3'h0, 2'h2, 16'h0202, 16'h0, 4'h6, 6'h3F, 2'h1, 32'h112},
            '{3'h7, 3'h0, 2'h2, 16'h8000, 16'h0, 4'h7, 6'h38, 2'h1,
              32'hFFFF_8000},
            '{3'h7, 3'h1, 2'h2, 16'h1234, 16'h5678, 4'h8, 6'h38, 2'h1,
              32'h1234_5678},
            '{3'h7, 3'h2, 2'h2, 16'h0010, 16'h0, 4'h9, 6'h38, 2'h1, 32'h1012},
            '{3'h7, 3'h3, 2'h2, 16'h0CFC, 16'h0, 4'hA, 6'h38, 2'h1, 32'h101E},
            '{3'h7, 3'h4, 2'h2, 16'h1234, 16'h5678, 4'hB, 6'h30, 2'h2,
              32'h1234_5678},
            '{3'h7, 3'h4, 2'h0, 16'h00A5, 16'h0, 4'hB, 6'h30, 2'h2, 32'hA5},
            '{3'h7, 3'h5, 2'h2, 16'h0, 16'h0, 4'hC, 6'h00, 2'h0, 32'h0}};
        ops = '{16'h4E4B, 16'hA000, 16'hC100, 16'h8100, 16'h4800,
                16'hE8C0, 16'hE018, 16'hE6C0, 16'h50C8, 16'h4C00};
        repeat (5) @(negedge clk);
        rst = 1'b0;
        // Back-to-back table rows, one per cycle
        foreach (rows[i]) begin
            {req.mode, req.regf} = {rows[i].m, rows[i].r};
            req.size = ea_pkg::op_size_t'(rows[i].sz);
            {req.ext0, req.ext1} = {rows[i].e0, rows[i].e1};
            tick;
            chk(result.valid, 1'b1);
            chk(result.mode, rows[i].em);
            chk(result.cat, rows[i].cat);
            if (rows[i].m != 3'h7)
                chk(result.reg_num, rows[i].r);
            if (rows[i].k == 2'h1)
                chk(result.address, rows[i].ev);
            if (rows[i].k == 2'h2)
                chk(result.immediate, rows[i].ev);
            // Postincrement longword steps by four; index fields decoded
            if (i == 3) begin
                chk(result.an_update, 1'b1);
                chk(result.an_next, 32'h104);
            end
            if (i == 7) begin
                chk(result.idx_is_areg, 1'b1);
                chk(result.idx_num, 3'h3);
            end
            if (i == 13) chk(result.ext_words, 2'h2);
        end
        // Trap, multiply-accumulate line and dropped opcodes
        {req.mode, req.regf, req.ext0} = {6'h10, 16'h0400};
        for (int j = 0; j < 10; j++) begin
            req.op_word = ops[j];
            tick;
            chk(trap_valid, j == 0);
            if (j == 0) chk(trap_vector, 4'hB);
            chk(mac_op, j == 1);
            chk(removed_op, j > 1);
        end
        // Flags, register merge at byte and word, memory order at long and word
        {status_word, flags_we, flags_wdata} = {16'h2715, 1'b1, 8'hA5};
        {dest_old, alu_result} = {32'h1122_3344, 32'hAABB_CCDD};
        {src_value, store_data} = {32'h0000_8001, 32'hA1B2_C3D4};
        req.op_word = 16'h0000;
        req.size = ea_pkg::SIZE_LONG;
        reg_size = ea_pkg::SIZE_BYTE;
        tick;
        chk(condition_flags, 8'h15);
        chk(next_status_word, 16'h27A5);
        chk(dest_merged, 32'h1122_33DD);
        chk(layout.first_part, 16'hA1B2);
        chk(layout.second_part, 16'hC3D4);
        chk(layout.second_addr, 32'h102);
        chk(layout.first_addr, 32'h100);
        req.size = ea_pkg::SIZE_WORD;
        reg_size = ea_pkg::SIZE_WORD;
        tick;
        chk(dest_merged, 32'h1122_CCDD);
        chk(src_operand, 32'hFFFF_8001);
        chk(layout.first_part[7:0], 8'hC3);
        chk(layout.second_addr, 32'h101);
        dest_is_areg = 1'b1;
        tick;
        chk(dest_merged, 32'hFFFF_CCDD);
        // Enable low holds every output despite new inputs
        ce = 1'b0;
        status_word = 16'h0000;
        tick;
        chk(condition_flags, 8'h15);
        chk(dest_merged, 32'hFFFF_CCDD);
        ce = 1'b1;
        // Reset in mid-run clears outputs despite a valid request
        rst = 1'b1;
        tick;
        chk(result.valid, 1'b0);
        chk(condition_flags, 8'h00);
        end_of_test;
    end
endmodule : test_ea_mode_decoder
